// ---- design/itas_pkg.sv ----
package itas_pkg;
   // ********************************
   // register map
   // ********************************
   localparam int unsigned AW             = 32;
   localparam int unsigned DW             = 16;
   localparam logic [31:0] CAUSE_ADDR     = 32'h5000_1380;
   localparam logic [31:0] CTRL_ADDR      = 32'h5000_1300;
   localparam logic [31:0] TARGET_ADDR    = 32'h5000_1304;
   localparam logic [31:0] DATA_CMD_ADDR  = 32'h5000_1310;
   localparam logic [31:0] CLR_ABORT_ADDR = 32'h5000_1354;
   localparam logic [31:0] ENABLE_ADDR    = 32'h5000_136c;
   localparam logic [31:0] STATUS_ADDR    = 32'h5000_13a0;
   // ********************************
   // abort cause bit positions
   // ********************************
   localparam int unsigned B_SLV_RD_MISUSE = 15;
   localparam int unsigned B_SLV_LOST      = 14;
   localparam int unsigned B_SLV_FLUSH     = 13;
   localparam int unsigned B_ARBITRATION_LOST_FLAG      = 12;
   localparam int unsigned B_MST_DIS       = 11;
   localparam int unsigned B_TEN_RD_NORST  = 10;
   localparam int unsigned B_SBYTE_NORST   = 9;
   localparam int unsigned B_HS_NORST      = 8;
   localparam int unsigned B_SBYTE_ACKED   = 7;
   localparam int unsigned B_HS_ACKED      = 6;
   localparam int unsigned B_GCALL_READ    = 5;
   localparam int unsigned B_GCALL_UNACK   = 4;
   localparam int unsigned B_DATA_UNACK    = 3;
   localparam int unsigned B_TEN2_UNACK    = 2;
   localparam int unsigned B_TEN1_UNACK    = 1;
   localparam int unsigned B_SEVEN_UNACK   = 0;
   // ********************************
   // control fields
   // ********************************
   localparam int unsigned CTL_MST_EN   = 0;
   localparam int unsigned CTL_TEN_BIT  = 1;
   localparam int unsigned CTL_HS_MODE  = 2;
   localparam int unsigned CTL_RESTART  = 5;
   localparam int unsigned TAR_GC_START = 10;
   localparam int unsigned TAR_CMD_SEL  = 11;
   localparam int unsigned DC_READ      = 8;
   localparam int unsigned DC_GC_READ   = 9;
   localparam int unsigned EN_BIT       = 0;
   localparam int unsigned ST_IRQ       = 0;
   localparam int unsigned ST_EN        = 1;
   localparam int unsigned ST_SB_CAUSE  = 2;
   localparam logic [15:0] CAUSE_RST    = 16'h0000;
   localparam logic [15:0] CTRL_RST     = 16'h0021;
   localparam logic [15:0] TARGET_RST   = 16'h0000;
   localparam logic        EN_RST       = 1'b0;
   typedef enum logic [2:0] {
      ack_seven  = 3'h0,
      ack_ten1   = 3'h1,
      ack_ten2   = 3'h3,
      ack_data   = 3'h2,
      ack_gcall  = 3'h6,
      ack_sbyte  = 3'h7,
      ack_hscode = 3'h5
   } itas_ack_e;
endpackage

// ---- design/itas_top.sv ----
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module itas_top (
   input  wire logic                      i_clk,
   input  wire logic                      i_rst,
   input  wire logic [itas_pkg::AW-1:0]   i_addr,
   input  wire logic [itas_pkg::DW-1:0]   i_wdata,
   input  wire logic                      i_wr,
   input  wire logic                      i_rd,
   output logic      [itas_pkg::DW-1:0]   o_rdata,
   input  wire logic                      i_scl,
   input  wire logic                      i_sda,
   input  wire logic                      i_mst_drv,
   input  wire logic                      i_mst_bit,
   input  wire logic                      i_slv_drv,
   input  wire logic                      i_slv_bit,
   input  wire logic                      i_slv_rd_busy,
   input  wire logic                      i_slv_rd_cmd,
   input  wire logic                      i_txf_empty,
   input  wire logic                      i_ack_stb,
   input  wire itas_pkg::itas_ack_e       i_ack_kind,
   input  wire logic                      i_ack_nak,
   output logic                           o_txf_wr,
   output logic      [9:0]                o_txf_data,
   output logic                           o_txf_flush,
   output logic                           o_rxf_flush,
   output logic                           o_halt,
   output logic                           o_tx_abort_irq
);
   import itas_pkg::*;

   // ********************************
   // registers
   // ********************************
   logic [15:0] cause_r;
   logic [15:0] cause_nxt;
   logic [15:0] ctrl_r;
   logic [15:0] target_r;
   logic        en_r;
   logic        irq_r;
   logic        irq_nxt;
   logic        sb_rearm_r;
   logic        halt_r;
   logic        txf_flush_r;
   logic        rxf_flush_r;
   logic        txf_wr_r;
   logic [9:0]  txf_data_r;
   logic [15:0] rdata_r;
   logic        scl_q1;
   logic        scl_q2;
   logic        scl_q3;
   logic        sda_q1;
   logic        sda_q2;

   // ********************************
   // address decode
   // ********************************
   wire ctrl_wr   = i_wr && (i_addr == CTRL_ADDR);
   wire target_wr = i_wr && (i_addr == TARGET_ADDR);
   wire en_wr     = i_wr && (i_addr == ENABLE_ADDR);
   wire dc_wr     = i_wr && (i_addr == DATA_CMD_ADDR);
   wire clr       = i_rd && (i_addr == CLR_ABORT_ADDR);

   // ********************************
   // configuration fields
   // ********************************
   wire mst_en   = ctrl_r[CTL_MST_EN];
   wire ten_bit  = ctrl_r[CTL_TEN_BIT];
   wire hs_mode  = ctrl_r[CTL_HS_MODE];
   wire no_rst   = !ctrl_r[CTL_RESTART];
   wire cmd_sel  = target_r[TAR_CMD_SEL];
   wire gc_start = target_r[TAR_GC_START];
   wire sbyte_sel = cmd_sel && gc_start;
   wire gcall_sel = cmd_sel && !gc_start;
   // start-byte cause as a level, so bit 9 can come back after a clear
   wire sb_cause = mst_en && no_rst && sbyte_sel;

   wire [15:0] status_val = {13'h0000, sb_cause, en_r, irq_r};
   wire [15:0] rd_val =
      (i_addr == CAUSE_ADDR)     ? cause_r    :
      (i_addr == CTRL_ADDR)      ? ctrl_r     :
      (i_addr == TARGET_ADDR)    ? target_r   :
      (i_addr == ENABLE_ADDR)    ? {15'h0000, en_r} :
      (i_addr == STATUS_ADDR)    ? status_val :
      (i_addr == CLR_ABORT_ADDR) ? {15'h0000, irq_r} :
      16'h0000;

   // ********************************
   // software command word
   // ********************************
   // a data-command write while the slave is serving a read is the slave's answer
   wire slv_wr = dc_wr && i_slv_rd_busy;
   wire mst_wr = dc_wr && !i_slv_rd_busy;
   wire mst_ok = mst_wr && mst_en;
   wire wr_rd  = i_wdata[DC_READ];

   // ********************************
   // link sampling
   // ********************************
   // sampled data lags the clock by the synchroniser; the driving side
   // holds its bit through the high phase, so the compare stays valid
   wire scl_rise = scl_q2 && !scl_q3;
   wire mst_miss = scl_rise && i_mst_drv && (sda_q2 != i_mst_bit);
   wire slv_miss = scl_rise && i_slv_drv && (sda_q2 != i_slv_bit);

   // ********************************
   // cause events
   // ********************************
   wire ack_ok  = i_ack_stb && !i_ack_nak;
   wire ack_nak = i_ack_stb && i_ack_nak;
   logic [15:0] set_vec;
   assign set_vec[B_SLV_RD_MISUSE] = slv_wr && wr_rd;
   assign set_vec[B_SLV_LOST]      = slv_miss;
   assign set_vec[B_SLV_FLUSH]     = i_slv_rd_cmd && !i_txf_empty;
   assign set_vec[B_ARBITRATION_LOST_FLAG]      = mst_miss || slv_miss;
   assign set_vec[B_MST_DIS]       = mst_wr && !mst_en;
   assign set_vec[B_TEN_RD_NORST]  = mst_ok && no_rst && ten_bit && wr_rd;
   assign set_vec[B_SBYTE_NORST]   = (mst_ok && sb_cause)
                                   || (sb_rearm_r && sb_cause);
   assign set_vec[B_HS_NORST]      = mst_ok && no_rst && hs_mode;
   assign set_vec[B_SBYTE_ACKED]   = ack_ok && (i_ack_kind == ack_sbyte);
   assign set_vec[B_HS_ACKED]      = ack_ok && hs_mode
                                   && (i_ack_kind == ack_hscode);
   assign set_vec[B_GCALL_READ]    = mst_ok && gcall_sel && i_wdata[DC_GC_READ];
   assign set_vec[B_GCALL_UNACK]   = ack_nak && (i_ack_kind == ack_gcall);
   // acknowledge strobes only come from the master side
   assign set_vec[B_DATA_UNACK]    = ack_nak && (i_ack_kind == ack_data);
   assign set_vec[B_TEN2_UNACK]    = ack_nak && ten_bit
                                   && (i_ack_kind == ack_ten2);
   assign set_vec[B_TEN1_UNACK]    = ack_nak && ten_bit
                                   && (i_ack_kind == ack_ten1);
   assign set_vec[B_SEVEN_UNACK]   = ack_nak && !ten_bit
                                   && (i_ack_kind == ack_seven);

   wire any_set = |set_vec;
   // a fresh event beats a clear in the same cycle
   assign cause_nxt = (clr ? CAUSE_RST : cause_r) | set_vec;
   assign irq_nxt   = (clr ? 1'b0 : irq_r) | any_set;
   // rejected writes never reach the fifo
   wire push = dc_wr && en_r && !any_set;

   // ********************************
   // sequential logic
   // ********************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         scl_q1 <= 1'b1;
         scl_q2 <= 1'b1;
         scl_q3 <= 1'b1;
         sda_q1 <= 1'b1;
         sda_q2 <= 1'b1;
      end else begin
         scl_q1 <= i_scl;
         scl_q2 <= scl_q1;
         scl_q3 <= scl_q2;
         sda_q1 <= i_sda;
         sda_q2 <= sda_q1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_r   <= CTRL_RST;
         target_r <= TARGET_RST;
         en_r     <= EN_RST;
      end else begin
         if (ctrl_wr) begin
            ctrl_r <= i_wdata;
         end
         if (target_wr) begin
            target_r <= i_wdata;
         end
         if (en_wr) begin
            en_r <= i_wdata[EN_BIT];
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cause_r    <= CAUSE_RST;
         irq_r      <= 1'b0;
         sb_rearm_r <= 1'b0;
      end else begin
         cause_r    <= cause_nxt;
         irq_r      <= irq_nxt;
         sb_rearm_r <= clr && sb_cause && cause_r[B_SBYTE_NORST];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         halt_r      <= 1'b0;
         txf_flush_r <= 1'b1;
         rxf_flush_r <= 1'b1;
      end else begin
         halt_r      <= any_set;
         txf_flush_r <= any_set || !en_r;
         rxf_flush_r <= !en_r;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         txf_wr_r   <= 1'b0;
         txf_data_r <= 10'h000;
         rdata_r    <= 16'h0000;
      end else begin
         txf_wr_r   <= push;
         txf_data_r <= push ? i_wdata[9:0] : txf_data_r;
         rdata_r    <= i_rd ? rd_val : 16'h0000;
      end
   end

   assign o_rdata        = rdata_r;
   assign o_txf_wr       = txf_wr_r;
   assign o_txf_data     = txf_data_r;
   assign o_txf_flush    = txf_flush_r;
   assign o_rxf_flush    = rxf_flush_r;
   assign o_halt         = halt_r;
   assign o_tx_abort_irq = irq_r;

   // ********************************
   // assertions
   // ********************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_sb_clear;
      clr && sb_cause && cause_r[B_SBYTE_NORST] && !dc_wr;
   endsequence
   sequence s_sb_back;
      !cause_r[B_SBYTE_NORST] ##1 cause_r[B_SBYTE_NORST];
   endsequence
   sequence s_abort_effects;
      o_halt && o_txf_flush && o_tx_abort_irq;
   endsequence

   a_slv_read_misuse: assert property (
      slv_wr && wr_rd |=> cause_r[B_SLV_RD_MISUSE] && o_tx_abort_irq)
      else $error("slave read misuse not flagged");
   a_slv_lost_pair: assert property (
      $rose(cause_r[B_SLV_LOST]) |-> cause_r[B_ARBITRATION_LOST_FLAG])
      else $error("slave bus loss without arbitration flag");
   a_mismatch_lost: assert property (
      scl_rise && i_mst_drv && (sda_q2 != i_mst_bit) |=> cause_r[B_ARBITRATION_LOST_FLAG])
      else $error("data mismatch did not lose the bus");
   a_stale_flush: assert property (
      i_slv_rd_cmd && !i_txf_empty |=> cause_r[B_SLV_FLUSH] && o_txf_flush)
      else $error("stale fifo flush missing");
   a_master_disabled: assert property (
      mst_wr && !mst_en |=> cause_r[B_MST_DIS] && !o_txf_wr)
      else $error("master disabled abort missing");
   a_ten_rd_norst: assert property (
      mst_ok && no_rst && ten_bit && wr_rd |=> cause_r[B_TEN_RD_NORST])
      else $error("ten-bit read without restart not flagged");
   a_sbyte_rearm: assert property (
      s_sb_clear ##1 sb_cause |-> s_sb_back)
      else $error("start byte cause did not re-assert");
   a_gcall_unack: assert property (
      ack_nak && (i_ack_kind == ack_gcall) |=> cause_r[B_GCALL_UNACK])
      else $error("general call no-ack not flagged");
   a_seven_unack: assert property (
      ack_nak && !ten_bit && (i_ack_kind == ack_seven) |=> cause_r[B_SEVEN_UNACK])
      else $error("seven-bit address no-ack not flagged");
   a_disable_flush: assert property (
      !en_r |=> o_rxf_flush && o_txf_flush)
      else $error("disabled controller did not flush");
   a_abort_halts: assert property (
      any_set |=> s_abort_effects)
      else $error("abort did not halt and flush");
   a_clear_all: assert property (
      clr && !any_set |=> (cause_r == CAUSE_RST) && !o_tx_abort_irq)
      else $error("clear on read left causes set");

   // each cause bit follows its event by one cycle
   sequence s_slv_pair;
      cause_r[B_SLV_LOST] && cause_r[B_ARBITRATION_LOST_FLAG];
   endsequence

   a_slv_lost_both: assert property (
      slv_miss |=> s_slv_pair)
      else $error("slave bus loss did not set both bits");
   a_arb_owner: assert property (
      $rose(cause_r[B_ARBITRATION_LOST_FLAG]) |-> $past(mst_miss) || $past(slv_miss))
      else $error("arbitration flag without a bus loss");
   a_sbyte_norst: assert property (
      mst_ok && sb_cause |=> cause_r[B_SBYTE_NORST])
      else $error("start byte without restart not flagged");
   a_hs_norst: assert property (
      mst_ok && no_rst && hs_mode |=> cause_r[B_HS_NORST])
      else $error("high-speed without restart not flagged");
   a_sbyte_acked: assert property (
      ack_ok && (i_ack_kind == ack_sbyte) |=> cause_r[B_SBYTE_ACKED])
      else $error("acknowledged start byte not flagged");
   a_hs_acked: assert property (
      ack_ok && hs_mode && (i_ack_kind == ack_hscode) |=> cause_r[B_HS_ACKED])
      else $error("acknowledged master code not flagged");
   a_gcall_read: assert property (
      mst_ok && gcall_sel && i_wdata[DC_GC_READ] |=> cause_r[B_GCALL_READ])
      else $error("read after general call not flagged");
   a_data_unack: assert property (
      ack_nak && (i_ack_kind == ack_data) |=> cause_r[B_DATA_UNACK])
      else $error("data no-ack not flagged");
   a_ten2_unack: assert property (
      ack_nak && ten_bit && (i_ack_kind == ack_ten2) |=> cause_r[B_TEN2_UNACK])
      else $error("second ten-bit address no-ack not flagged");
   a_ten1_unack: assert property (
      ack_nak && ten_bit && (i_ack_kind == ack_ten1) |=> cause_r[B_TEN1_UNACK])
      else $error("first ten-bit address no-ack not flagged");
   a_shared_word: assert property (
      i_slv_rd_cmd && !i_txf_empty && ack_nak && !ten_bit && (i_ack_kind == ack_seven)
      |=> cause_r[B_SLV_FLUSH] && cause_r[B_SEVEN_UNACK])
      else $error("master and slave causes not both kept");
   a_no_push_abort: assert property (
      any_set |=> !o_txf_wr)
      else $error("aborting write reached the fifo");
   a_halt_pulse: assert property (
      !any_set |=> !o_halt)
      else $error("halt without an abort");
   a_cause_sticky: assert property (
      !clr |=> ((cause_r & $past(cause_r)) == $past(cause_r)))
      else $error("cause bit dropped without a clear");
endmodule

// ---- tb/itas_bus_partner.sv ----
`timescale 1ns/1ps
module itas_bus_partner (
   input  wire logic       i_go,
   input  wire logic [7:0] i_byte,
   output logic            o_scl,
   output logic            o_sda,
   output logic            o_busy
);
   // *****
   // remote transmitter
   // *****
   // clock stands high between frames, both lines pulled up when idle
   initial begin
      o_scl  = 1'b1;
      o_sda  = 1'b1;
      o_busy = 1'b0;
   end
   always @(posedge i_go) begin
      o_busy = 1'b1;
      o_sda  = 1'b0;
      #62.5;
      for (int k = 7; k >= 0; k--) begin
         o_scl = 1'b0;
         #31.25;
         o_sda = i_byte[k];
         #31.25;
         o_scl = 1'b1;
         #62.5;
      end
      o_scl = 1'b0;
      #62.5;
      o_scl = 1'b1;
      #31.25;
      o_sda  = 1'b1;
      o_busy = 1'b0;
   end
endmodule

// ---- tb/test_i2c_tx_abort_source.sv ----
`timescale 1ns/1ps
module test_i2c_tx_abort_source;
   import itas_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic [31:0] i_addr = '0;
   logic [15:0] i_wdata = '0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic        mst_drv = 1'b0;
   logic        mst_bit = 1'b0;
   logic        slv_drv = 1'b0;
   logic        slv_bit = 1'b0;
   logic        rd_busy = 1'b0;
   logic        rd_cmd = 1'b0;
   logic        txf_empty = 1'b1;
   logic        ack_stb = 1'b0;
   logic        ack_nak = 1'b0;
   itas_ack_e   ack_kind = ack_seven;
   logic        go = 1'b0;
   logic [7:0]  pbyte = 8'h00;
   logic        scl, sda, busy, txf_wr, txf_flush, rxf_flush, halt, irq;
   logic [15:0] rdata;
   logic [9:0]  txf_data;
   int          err_total = 0;
   int          checked = 0;
   logic [15:0] d;
   logic [31:0] v;
   itas_ack_e   ks[7] = '{ack_seven, ack_ten1, ack_ten2, ack_data, ack_gcall, ack_sbyte,
                          ack_hscode};
   logic [15:0] wc_ctl[5] = '{16'h0021, 16'h0020, 16'h0003, 16'h0005, 16'h0021};
   logic [15:0] wc_tar[5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0800};
   logic [15:0] wc_dc[5]  = '{16'h0100, 16'h0000, 16'h0100, 16'h0000, 16'h0200};
   logic [15:0] wc_exp[5] = '{16'h8000, 16'h0800, 16'h0400, 16'h0100, 16'h0020};
   always #5 i_clk = ~i_clk;
   itas_top itas_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_scl(scl), .i_sda(sda),
      .i_mst_drv(mst_drv), .i_mst_bit(mst_bit), .i_slv_drv(slv_drv), .i_slv_bit(slv_bit),
      .i_slv_rd_busy(rd_busy), .i_slv_rd_cmd(rd_cmd), .i_txf_empty(txf_empty),
      .i_ack_stb(ack_stb), .i_ack_kind(ack_kind), .i_ack_nak(ack_nak), .o_txf_wr(txf_wr),
      .o_txf_data(txf_data), .o_txf_flush(txf_flush), .o_rxf_flush(rxf_flush),
      .o_halt(halt), .o_tx_abort_irq(irq));
   itas_bus_partner itas_bus_partner_i (.i_go(go), .i_byte(pbyte), .o_scl(scl),
      .o_sda(sda), .o_busy(busy));
   // *****
   // tasks
   // *****
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // strobes drop with an idle cycle after, so no signal is set twice in one step
   task automatic wr(input logic [31:0] a, input logic [15:0] w);
      i_addr  <= a;
      i_wdata <= w;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rd(input logic [31:0] a);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      // read data stand only this cycle; take them once settled
      #1;
      d = rdata;
      @(posedge i_clk);
   endtask
   task automatic ack(input itas_ack_e k, input logic n);
      ack_kind <= k;
      ack_nak  <= n;
      ack_stb  <= 1'b1;
      @(posedge i_clk);
      ack_stb <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic chk(input logic [15:0] exp);
      rd(CAUSE_ADDR);
      cmp(d, exp);
      if (exp != 16'h0) begin
         cmp({15'h0, irq}, 16'h1);
         rd(CLR_ABORT_ADDR);
         cmp(d, 16'h1);
         rd(CAUSE_ADDR);
         cmp(d, 16'h0);
         cmp({15'h0, irq}, 16'h0);
      end
   endtask
   task automatic frame(input logic m, input logic b, input logic [7:0] p,
                        input logic [15:0] exp);
      pbyte   <= p;
      mst_drv <= m;
      slv_drv <= !m;
      mst_bit <= b;
      slv_bit <= b;
      go      <= 1'b1;
      @(posedge i_clk);
      go <= 1'b0;
      for (int n = 0; n < 300 && (n < 4 || busy); n++)
         @(posedge i_clk);
      mst_drv <= 1'b0;
      slv_drv <= 1'b0;
      repeat (4) @(posedge i_clk);
      chk(exp);
   endtask
   function automatic logic [15:0] ack_exp(input itas_ack_e k, input logic n);
      int b;
      case (k)
         ack_seven: b = B_SEVEN_UNACK;
         ack_ten1:  b = B_TEN1_UNACK;
         ack_ten2:  b = B_TEN2_UNACK;
         ack_data:  b = B_DATA_UNACK;
         ack_gcall: b = B_GCALL_UNACK;
         ack_sbyte: b = B_SBYTE_ACKED;
         default:   b = B_HS_ACKED;
      endcase
      // start byte and master code fail when acked, the rest when not
      return ((k == ack_sbyte || k == ack_hscode) != n) ? 16'h1 << b : 16'h0;
   endfunction
   function automatic logic [15:0] lost_exp(input logic m, input logic b, input logic [7:0] p);
      // the line carries the remote byte; any differing intended bit loses the bus
      if (p == {8{b}}) begin
         return 16'h0000;
      end
      return m ? 16'h1000 : 16'h5000;
   endfunction
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // *****
   // tests
   // *****
   initial begin
      void'($urandom(32'h72cec856));
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      rd(CTRL_ADDR);
      cmp(d, CTRL_RST);
      rd(TARGET_ADDR);
      cmp(d, TARGET_RST);
      rd(32'h5000_1390);
      cmp(d, 16'h0);
      cmp({14'h0, txf_flush, rxf_flush}, 16'h3);
      wr(CAUSE_ADDR, 16'hffff);
      chk(CAUSE_RST);
      wr(ENABLE_ADDR, 16'h1);
      repeat (3) @(posedge i_clk);
      cmp({14'h0, txf_flush, rxf_flush}, 16'h0);
      $display("test registers finished");
      for (int i = 0; i < 14; i++) begin
         wr(CTRL_ADDR, ks[i/2] inside {ack_ten1, ack_ten2} ? 16'h23 :
            ks[i/2] == ack_hscode ? 16'h25 : 16'h21);
         ack(ks[i/2], i[0]);
         chk(ack_exp(ks[i/2], i[0]));
      end
      $display("test acknowledge slots finished");
      for (int i = 0; i < 5; i++) begin
         wr(CTRL_ADDR, wc_ctl[i]);
         wr(TARGET_ADDR, wc_tar[i]);
         rd_busy <= (i == 0);
         wr(DATA_CMD_ADDR, wc_dc[i]);
         cmp({15'h0, txf_wr}, 16'h0);
         rd_busy <= 1'b0;
         chk(wc_exp[i]);
      end
      wr(CTRL_ADDR, 16'h01);
      wr(TARGET_ADDR, 16'hc00);
      wr(DATA_CMD_ADDR, 16'h0);
      rd(CAUSE_ADDR);
      cmp(d, 16'h0200);
      rd(CLR_ABORT_ADDR);
      @(posedge i_clk);
      rd(CAUSE_ADDR);
      cmp(d, 16'h0200);
      rd(STATUS_ADDR);
      cmp(d, 16'h0007);
      wr(TARGET_ADDR, 16'h0);
      chk(16'h0200);
      $display("test command checks finished");
      wr(CTRL_ADDR, CTRL_RST);
      txf_empty <= 1'b0;
      rd_cmd    <= 1'b1;
      ack_kind  <= ack_seven;
      ack_nak   <= 1'b1;
      ack_stb   <= 1'b1;
      @(posedge i_clk);
      rd_cmd    <= 1'b0;
      ack_stb   <= 1'b0;
      txf_empty <= 1'b1;
      @(posedge i_clk);
      chk(16'h2001);
      frame(1'b1, 1'b1, 8'h00, 16'h1000);
      frame(1'b0, 1'b1, 8'h00, 16'h5000);
      frame(1'b1, 1'b0, 8'h00, 16'h0000);
      frame(1'b1, 1'b1, 8'hff, 16'h0000);
      v = $urandom;
      frame(v[8], v[9], v[7:0], lost_exp(v[8], v[9], v[7:0]));
      $display("test bus loss finished");
      for (int i = 0; i < 20; i++) begin
         v = $urandom;
         wr(DATA_CMD_ADDR, {6'h0, v[9:0]});
         cmp({15'h0, txf_wr}, 16'h1);
         cmp({6'h0, txf_data}, {6'h0, v[9:0]});
         ack(v[12] ? ack_data : ack_seven, 1'b0);
      end
      chk(16'h0);
      wr(ENABLE_ADDR, 16'h0);
      repeat (3) @(posedge i_clk);
      cmp({14'h0, txf_flush, rxf_flush}, 16'h3);
      $display("test pushes and disable finished");
      ack(ack_seven, 1'b1);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      rd(CAUSE_ADDR);
      cmp(d, CAUSE_RST);
      cmp({15'h0, irq}, 16'h0);
      $display("test mid-run reset finished");
      give_verdict();
   end
   initial begin
      // tests need about a thousand cycles
      #200_000;
      err_total++;
      give_verdict();
   end
endmodule
